// File: hdl/t2cr_pkg.sv
// Notes on behaviour
// - timer steps each or every second machine cycle
// - gated timer counts only while gate high
// - gate pin sampled once per machine cycle
// - counter steps on sampled high-then-low pin
// - counted value lands one machine cycle later
// - rollover to zero sets overflow flag bit 6
// - both flags share one interrupt request
// - input field: stop, timer, counter, gated
// - reload field: off, on overflow, on edge
// - overflow reload replaces zero same cycle
// - trigger edge reloads, flags when enabled
// - enabled interrupt follows external reload flag
// - trigger sampled, reload one cycle after edge
// - compare mode bit selects mode 1 or 0
package t2cr_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // ************************************************
    // register offsets
    // ************************************************
    localparam logic [ADDR_W-1:0] ADDR_CONTROL   = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_LO  = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_HI  = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_RELOAD_LO = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_RELOAD_HI = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CTRL  = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN    = 3'h6;

    // ************************************************
    // field positions and values
    // ************************************************
    localparam int BIT_INSEL_LO  = 0;
    localparam int BIT_INSEL_HI  = 1;
    localparam int BIT_CMP_MODE  = 2;
    localparam int BIT_RELSEL_LO = 3;
    localparam int BIT_RELSEL_HI = 4;
    localparam int BIT_PRESCALE  = 7;
    localparam int BIT_OVF_FLAG  = 6;
    localparam int BIT_EXT_FLAG  = 7;
    localparam int BIT_EXT_EN    = 3;
    localparam int BIT_T2_IE     = 5;

    localparam logic [1:0] INSEL_STOP  = 2'h0;
    localparam logic [1:0] INSEL_TIMER = 2'h1;
    localparam logic [1:0] INSEL_COUNT = 2'h2;
    localparam logic [1:0] INSEL_GATED = 2'h3;
    localparam logic [1:0] RELSEL_OVF  = 2'h2;
    localparam logic [1:0] RELSEL_EDGE = 2'h3;

    localparam logic [DATA_W-1:0] CONTROL_MASK  = 8'h9f;
    localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] IRQ_EN_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ZERO     = 8'h00;
    localparam logic [15:0]       COUNT_MAX     = 16'hffff;
    localparam logic [15:0]       COUNT_ZERO    = 16'h0000;
    localparam logic [15:0]       COUNT_ONE     = 16'h0001;

    // oscillator periods in one machine cycle
    localparam int OSC_PER_MCYC = 12;

endpackage : t2cr_pkg

// File: hdl/t2cr_timer.sv
`timescale 1ns/1ps
module t2cr_timer #(
    parameter int MCYC_DIV = t2cr_pkg::OSC_PER_MCYC
) (
    input  wire logic                         clk_sys,
    input  wire logic                         rst_n,
    input  wire logic [t2cr_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [t2cr_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [t2cr_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                         ext_count_gate_pin,
    input  wire logic                         reload_trigger_pin,
    output logic                              timer2_irq_req,
    output logic                              compare_mode_out
);
    import t2cr_pkg::*;

    // ************************************************
    // registers and pipeline state
    // ************************************************
    logic [DATA_W-1:0] timer2_control;
    logic [15:0]       count;
    logic [15:0]       reload_value;
    logic              overflow_flag;
    logic              ext_reload_flag;
    logic              ext_reload_enable;
    logic              timer2_int_enable;
    logic [3:0]        div;
    logic              mcyc;
    logic              cg_meta;
    logic              cg_sync;
    logic              cg_smp;
    logic              trig_meta;
    logic              trig_sync;
    logic              trig_smp;
    logic              ps_half;
    logic              cnt_pend;
    logic              rel_pend;
    logic [1:0]        input_select;
    logic [1:0]        reload_select;
    logic              prescale_select;
    logic              gate_open;
    logic              timer_step;
    logic              step;
    logic              wrap;
    logic              cnt_edge;
    logic              trig_edge;
    logic              edge_reload;
    logic              wr_count_lo;
    logic              wr_count_hi;
    logic              set_ovf;
    logic              set_exf;
    logic [15:0]       next_count;

    localparam logic [3:0] DIV_LAST = 4'(MCYC_DIV - 1);

    function automatic logic [DATA_W-1:0] byte_of(input logic [15:0] w, input logic hi);
        byte_of = hi ? w[15:8] : w[7:0];
    endfunction : byte_of

    assign input_select    = {timer2_control[BIT_INSEL_HI], timer2_control[BIT_INSEL_LO]};
    assign reload_select   = {timer2_control[BIT_RELSEL_HI], timer2_control[BIT_RELSEL_LO]};
    assign prescale_select = timer2_control[BIT_PRESCALE];
    assign compare_mode_out = timer2_control[BIT_CMP_MODE];

    assign wr_count_lo = reg_wr && (reg_addr == ADDR_COUNT_LO);
    assign wr_count_hi = reg_wr && (reg_addr == ADDR_COUNT_HI);

    // ************************************************
    // machine cycle divider
    // ************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div <= 4'h0;
        end else if (div == DIV_LAST) begin
            div <= 4'h0;
        end else begin
            div <= div + 4'h1;
        end
    end

    assign mcyc = (div == DIV_LAST);

    // ************************************************
    // pin synchronisers and machine cycle samples
    // ************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cg_meta   <= 1'b0;
            cg_sync   <= 1'b0;
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
        end else begin
            cg_meta   <= ext_count_gate_pin;
            cg_sync   <= cg_meta;
            trig_meta <= reload_trigger_pin;
            trig_sync <= trig_meta;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cg_smp   <= 1'b0;
            trig_smp <= 1'b0;
        end else if (mcyc) begin
            cg_smp   <= cg_sync;
            trig_smp <= trig_sync;
        end
    end

    assign cnt_edge  = mcyc && cg_smp && !cg_sync && (input_select == INSEL_COUNT);
    assign trig_edge = mcyc && trig_smp && !trig_sync && (reload_select == RELSEL_EDGE);

    // ************************************************
    // count rate
    // ************************************************
    // gate opens internal clock
    assign gate_open = (input_select == INSEL_TIMER)
                    || ((input_select == INSEL_GATED) && cg_sync);

    // prescaler phase only advances on gated-through cycles
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ps_half <= 1'b0;
        end else if (mcyc && gate_open) begin
            ps_half <= !ps_half;
        end
    end

    assign timer_step = mcyc && gate_open && (!prescale_select || ps_half);

    // count one machine cycle after detection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_pend <= 1'b0;
        end else if (mcyc) begin
            cnt_pend <= cnt_edge;
        end
    end

    // reload one machine cycle after detection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rel_pend <= 1'b0;
        end else if (mcyc) begin
            rel_pend <= trig_edge;
        end
    end

    assign step        = timer_step
                      || (mcyc && cnt_pend && (input_select == INSEL_COUNT));
    assign wrap        = step && (count == COUNT_MAX);
    assign edge_reload = mcyc && rel_pend;

    // ************************************************
    // counter update
    // ************************************************
    always_comb begin
        next_count = count;
        if (edge_reload) begin
            next_count = reload_value;
        end else if (wrap) begin
            next_count = (reload_select == RELSEL_OVF) ? reload_value : COUNT_ZERO;
        end else if (step) begin
            next_count = count + COUNT_ONE;
        end
        if (wr_count_lo) begin
            next_count[7:0] = reg_wdata;
        end
        if (wr_count_hi) begin
            next_count[15:8] = reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count <= COUNT_ZERO;
        end else begin
            count <= next_count;
        end
    end

    // ************************************************
    // flags and request
    // ************************************************
    // rollover sets overflow flag
    assign set_ovf = wrap;
    assign set_exf = edge_reload && ext_reload_enable;

    // software clears, a same-cycle set wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag   <= 1'b0;
            ext_reload_flag <= 1'b0;
        end else begin
            if (set_ovf) begin
                overflow_flag <= 1'b1;
            end else if (reg_wr && (reg_addr == ADDR_IRQ_CTRL)) begin
                overflow_flag <= reg_wdata[BIT_OVF_FLAG];
            end
            if (set_exf) begin
                ext_reload_flag <= 1'b1;
            end else if (reg_wr && (reg_addr == ADDR_IRQ_CTRL)) begin
                ext_reload_flag <= reg_wdata[BIT_EXT_FLAG];
            end
        end
    end

    assign timer2_irq_req = timer2_int_enable && (overflow_flag || ext_reload_flag);

    // ************************************************
    // register bus
    // ************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer2_control    <= CONTROL_RESET;
            reload_value      <= COUNT_ZERO;
            ext_reload_enable <= IRQ_EN_RESET[BIT_EXT_EN];
            timer2_int_enable <= IRQ_EN_RESET[BIT_T2_IE];
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CONTROL) begin
                timer2_control <= reg_wdata & CONTROL_MASK;
            end else if (reg_addr == ADDR_RELOAD_LO) begin
                reload_value[7:0] <= reg_wdata;
            end else if (reg_addr == ADDR_RELOAD_HI) begin
                reload_value[15:8] <= reg_wdata;
            end else if (reg_addr == ADDR_IRQ_EN) begin
                ext_reload_enable <= reg_wdata[BIT_EXT_EN];
                timer2_int_enable <= reg_wdata[BIT_T2_IE];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= BYTE_ZERO;
        end else if (reg_rd) begin
            if (reg_addr == ADDR_CONTROL) begin
                reg_rdata <= timer2_control;
            end else if (reg_addr == ADDR_COUNT_LO) begin
                reg_rdata <= byte_of(count, 1'b0);
            end else if (reg_addr == ADDR_COUNT_HI) begin
                reg_rdata <= byte_of(count, 1'b1);
            end else if (reg_addr == ADDR_RELOAD_LO) begin
                reg_rdata <= byte_of(reload_value, 1'b0);
            end else if (reg_addr == ADDR_RELOAD_HI) begin
                reg_rdata <= byte_of(reload_value, 1'b1);
            end else if (reg_addr == ADDR_IRQ_CTRL) begin
                reg_rdata <= ({7'h00, overflow_flag} << BIT_OVF_FLAG)
                           | ({7'h00, ext_reload_flag} << BIT_EXT_FLAG);
            end else if (reg_addr == ADDR_IRQ_EN) begin
                reg_rdata <= ({7'h00, ext_reload_enable} << BIT_EXT_EN)
                           | ({7'h00, timer2_int_enable} << BIT_T2_IE);
            end else begin
                reg_rdata <= BYTE_ZERO;
            end
        end else begin
            reg_rdata <= BYTE_ZERO;
        end
    end

    // ************************************************
    // assertions
    // ************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic quiet;
    assign quiet = !wr_count_lo && !wr_count_hi && !edge_reload;

    sequence s_cnt_edge;
        mcyc && cg_smp && !cg_sync && (input_select == INSEL_COUNT);
    endsequence

    sequence s_cnt_land;
        cnt_pend ##11 (mcyc && quiet && (input_select == INSEL_COUNT) && count != COUNT_MAX);
    endsequence

    a_timer_fast_rate: assert property (
        mcyc && (input_select == INSEL_TIMER) && !prescale_select && quiet
        && count != COUNT_MAX |=> count == $past(count) + COUNT_ONE)
        else $error("timer did not step on machine cycle");

    a_timer_slow_rate: assert property (
        mcyc && (input_select == INSEL_TIMER) && prescale_select && quiet ##12 mcyc && quiet
        && (input_select == INSEL_TIMER) && prescale_select |=> count != $past(count, 13))
        else $error("prescaled timer missed a step");

    a_gate_low_halt: assert property (
        mcyc && (input_select == INSEL_GATED) && !cg_sync && quiet
        |=> count == $past(count))
        else $error("gated timer counted with gate low");

    a_count_edge_lag: assert property (
        s_cnt_edge ##1 s_cnt_land |=> count == $past(count) + COUNT_ONE)
        else $error("counted edge did not land one machine cycle later");

    a_stop_holds: assert property (
        (input_select == INSEL_STOP) && quiet |=> $stable(count))
        else $error("stopped timer changed");

    a_ovf_flag_set: assert property (
        step && (count == COUNT_MAX) |=> overflow_flag)
        else $error("rollover did not set overflow flag");

    a_ovf_reload: assert property (
        wrap && (reload_select == RELSEL_OVF) && !wr_count_lo && !wr_count_hi
        && !edge_reload |=> count == $past(reload_value))
        else $error("overflow reload missing");

    a_edge_reload: assert property (
        trig_edge ##12 (mcyc && !wr_count_lo && !wr_count_hi)
        |=> count == $past(reload_value)
            && (ext_reload_flag == ($past(ext_reload_enable) || $past(ext_reload_flag, 13))))
        else $error("trigger edge reload wrong");

    a_irq_shared: assert property (
        $rose(overflow_flag) && timer2_int_enable |-> timer2_irq_req)
        else $error("overflow did not request interrupt");

    a_byte_write: assert property (
        wr_count_hi |=> count[15:8] == $past(reg_wdata))
        else $error("count high byte write lost");

endmodule : t2cr_timer

// File: verif/t2cr_pin_source.sv
`timescale 1ns/1ps
module t2cr_pin_source #(
    parameter int HOLD_CLKS = 24
) (
    input  wire logic clk_sys,
    output logic      ext_count_gate_pin,
    output logic      reload_trigger_pin
);
    // **********
    // pin driver
    // **********
    // both pins rest high, as a port latch holding a one would leave them
    initial begin
        ext_count_gate_pin = 1'b1;
        reload_trigger_pin = 1'b1;
    end

    // level held long
    // two machine cycles per level, so no level can slip between samples
    task automatic set_gate(input logic lvl);
        @(posedge clk_sys);
        ext_count_gate_pin <= lvl;
        repeat (HOLD_CLKS) @(posedge clk_sys);
    endtask : set_gate

    task automatic pulse_gate(input int n);
        repeat (n) begin
            set_gate(1'b0);
            set_gate(1'b1);
        end
    endtask : pulse_gate

    task automatic pulse_trig();
        @(posedge clk_sys);
        reload_trigger_pin <= 1'b0;
        repeat (HOLD_CLKS) @(posedge clk_sys);
        reload_trigger_pin <= 1'b1;
        repeat (HOLD_CLKS) @(posedge clk_sys);
    endtask : pulse_trig
endmodule : t2cr_pin_source

// File: verif/test_t2cr_timer.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module test_t2cr_timer;
    import t2cr_pkg::*;
    // **********
    // signals
    // **********
    logic              clk_sys   = 1'b0;
    logic              rst_n     = 1'b0;
    logic [ADDR_W-1:0] reg_addr  = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              gate_pin;
    logic              trig_pin;
    logic              irq;
    logic              cmp_mode;
    int                err_total   = 0;
    int                checks_done = 0;
    logic [15:0]       cnt;
    logic [7:0]        b;
    logic [7:0]        t_ctrl [6]  = '{8'h01, 8'h81, 8'h03, 8'h01, 8'h11, 8'h09};
    logic [15:0]       t_start [6] = '{16'h0000, 16'h0000, 16'h0000, 16'hfffe, 16'hfffe, 16'hfffe};
    int                t_wait [6]  = '{118, 238, 118, 22, 22, 22};
    logic [15:0]       t_exp [6]   = '{16'h000a, 16'h000a, 16'h000a, 16'h0000, 16'h1234, 16'h0000};
    logic [7:0]        t_flag [6]  = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h40, 8'h40};
    logic [7:0]        e_ctrl [4]  = '{8'h1a, 8'h1a, 8'h12, 8'h02};
    logic [7:0]        e_en [4]    = '{8'h28, 8'h20, 8'h28, 8'h28};
    logic [15:0]       e_exp [4]   = '{16'h1234, 16'h1234, 16'h0000, 16'h0000};
    logic [7:0]        e_flag [4]  = '{8'h80, 8'h00, 8'h00, 8'h00};

    always #12.5 clk_sys = ~clk_sys;

    t2cr_timer dut (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .ext_count_gate_pin (gate_pin),
        .reload_trigger_pin (trig_pin),
        .timer2_irq_req     (irq),
        .compare_mode_out   (cmp_mode)
    );

    t2cr_pin_source u_src (
        .clk_sys            (clk_sys),
        .ext_count_gate_pin (gate_pin),
        .reload_trigger_pin (trig_pin)
    );

    // **********
    // bus tasks
    // **********
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic rd16(output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(ADDR_COUNT_LO, lo);
        rd(ADDR_COUNT_HI, hi);
        v = {hi, lo};
    endtask : rd16

    task automatic load(input logic [15:0] v);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_COUNT_HI, v[15:8]);
        wr(ADDR_COUNT_LO, v[7:0]);
    endtask : load

    // counting window is k+2 clocks, from the mode write to the stop write
    task automatic run(input logic [7:0] c, input logic [15:0] s, input int k);
        load(s);
        wr(ADDR_CONTROL, c);
        repeat (k) @(posedge clk_sys);
        wr(ADDR_CONTROL, 8'h00);
        rd16(cnt);
    endtask : run

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // **********
    // tests
    // **********
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ADDR_CONTROL, b);
        `CHK("control reset", 8'h00, b)
        rd(ADDR_IRQ_CTRL, b);
        `CHK("irq ctrl reset", 8'h00, b)
        rd(3'h7, b);
        `CHK("unmapped", 8'h00, b)
        wr(ADDR_CONTROL, 8'hff);
        rd(ADDR_CONTROL, b);
        `CHK("control mask", 8'h9f, b)
        `CHK("compare mode on", 1'b1, cmp_mode)
        wr(ADDR_CONTROL, 8'h00);
        #1;
        `CHK("compare mode off", 1'b0, cmp_mode)
        load(16'h1234);
        rd16(cnt);
        `CHK("count bytes", 16'h1234, cnt)
        $display("test registers done");

        wr(ADDR_RELOAD_HI, 8'h12);
        wr(ADDR_RELOAD_LO, 8'h34);
        wr(ADDR_IRQ_EN, 8'h20);
        rd(ADDR_RELOAD_HI, b);
        `CHK("reload high", 8'h12, b)
        rd(ADDR_RELOAD_LO, b);
        `CHK("reload low", 8'h34, b)
        rd(ADDR_IRQ_EN, b);
        `CHK("irq enable", 8'h20, b)
        foreach (t_ctrl[i]) begin
            run(t_ctrl[i], t_start[i], t_wait[i]);
            `CHK("run count", t_exp[i], cnt)
            rd(ADDR_IRQ_CTRL, b);
            `CHK("ovf flag", t_flag[i], b)
            `CHK("irq req", (t_flag[i] != 8'h00), irq)
            wr(ADDR_IRQ_CTRL, 8'h00);
            #1;
            `CHK("irq cleared", 1'b0, irq)
        end
        u_src.set_gate(1'b0);
        run(8'h03, 16'h0000, 118);
        `CHK("gate low", 16'h0000, cnt)
        u_src.set_gate(1'b1);
        $display("test timer modes done");

        load(16'h0000);
        wr(ADDR_CONTROL, 8'h02);
        u_src.pulse_gate(3);
        repeat (48) @(posedge clk_sys);
        rd16(cnt);
        `CHK("events", 16'h0003, cnt)
        $display("test event count done");

        foreach (e_ctrl[i]) begin
            load(16'h0000);
            wr(ADDR_IRQ_EN, e_en[i]);
            wr(ADDR_CONTROL, e_ctrl[i]);
            u_src.pulse_trig();
            repeat (48) @(posedge clk_sys);
            rd16(cnt);
            `CHK("edge reload", e_exp[i], cnt)
            rd(ADDR_IRQ_CTRL, b);
            `CHK("ext flag", e_flag[i], b)
            `CHK("ext irq", (e_flag[i] != 8'h00), irq)
            wr(ADDR_IRQ_CTRL, 8'h00);
        end
        $display("test edge reload done");
        tally_and_finish();
    end
endmodule : test_t2cr_timer
